/* idd_dd_properties.sv */
// concurrent properties watching the decode and dispatch block ports
`timescale 1ns/100ps
module idd_dd_properties
   import idd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic uop_valid,
   input wire idd_uop_s uop,
   input wire idd_dp_s dp,
   input wire logic compat_mode,
   input wire logic [31:0] prefetch_buffer,
   input wire logic [7:0] operand_specifier_reg_r,
   input wire logic byte_taken_r,
   input wire logic instr_byte_request_r,
   input wire logic dispatch_rom_select_r,
   input wire logic load_dest_mode_test_r,
   input wire logic compat_high_byte_select_r,
   input wire logic [1:0] specifier_reg_control_r,
   input wire logic [3:0] alu_flags_r,
   input wire logic [3:0] program_status_flags_r,
   input wire logic [31:0] pc_r,
   input wire logic [31:0] dbus_r
);
   logic [7:0] cur_byte;
   logic [7:0] shifted;
   logic nat;
   logic cmp;
   // pc is even in compat mode, so the pc byte equals the low byte there
   assign cur_byte = 8'(prefetch_buffer >> {pc_r[1:0], 3'b000});
   assign shifted = {operand_specifier_reg_r[5:2], 1'b0, operand_specifier_reg_r[0],
      cur_byte[7:6]};
   assign nat = uop_valid && !compat_mode;
   assign cmp = uop_valid && compat_mode;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence cm_class_s;
      cmp && uop.kind == KIND_CLASS;
   endsequence
   sequence no_decode_s;
      uop_valid && uop.kind == KIND_NONE;
   endsequence
   spec_native_ctl_a: assert property (nat && uop.kind == KIND_SPEC |=>
      instr_byte_request_r && !dispatch_rom_select_r && load_dest_mode_test_r)
      else $error("native specifier controls wrong");
   spec_byte_load_a: assert property (nat && uop.kind == KIND_SPEC |=>
      operand_specifier_reg_r == $past(cur_byte) && pc_r == $past(pc_r) + 32'h1)
      else $error("native specifier load or pc step wrong");
   compat_spec_a: assert property (cmp && uop.kind == KIND_SPEC |=>
      !instr_byte_request_r && !compat_high_byte_select_r && $stable(pc_r))
      else $error("compat specifier controls wrong");
   dest_clear_a: assert property (cmp && uop.kind == KIND_SPEC && uop.func == 3'h6
      |=> specifier_reg_control_r == 2'h2 && !operand_specifier_reg_r[3])
      else $error("compat destination load wrong");
   opcode_no_byte_a: assert property (nat && uop.kind == KIND_OPCODE |=>
      !byte_taken_r && dispatch_rom_select_r && $stable(pc_r))
      else $error("opcode decode took a byte");
   getbyte_load_a: assert property (nat && uop.kind == KIND_GETBYTE |=>
      instr_byte_request_r && operand_specifier_reg_r == $past(cur_byte))
      else $error("get-byte load wrong");
   nooper_load_a: assert property (cmp && uop.kind == KIND_NOOPER |=>
      operand_specifier_reg_r == $past(cur_byte) && !load_dest_mode_test_r)
      else $error("no-operand load wrong");
   cm_shift_a: assert property (cm_class_s ##1 no_decode_s |=>
      specifier_reg_control_r == 2'h1 && !compat_high_byte_select_r
      && operand_specifier_reg_r == $past(shifted)) else $error("compat shift wrong");
   cc_commit_a: assert property (uop_valid && dp.cc_commit |=>
      program_status_flags_r == $past(alu_flags_r)) else $error("flag copy wrong");
   dbus_blank_a: assert property (!uop_valid |=> dbus_r == 32'h0)
      else $error("d bus not blanked");
endmodule : idd_dd_properties

/* idd_decode_dispatch.sv */
// instruction decode, dispatch and data path register block
`timescale 1ns/100ps
`include "idd_defs.svh"

//////////////////////////////////////////////////////////////////////////////
module idd_decode_dispatch
   import idd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic uop_valid,
   input wire idd_uop_s uop,
   input wire idd_dp_s dp,
   input wire logic compat_mode,
   input wire logic [31:0] prefetch_buffer,
   input wire logic [31:0] ybus,
   input wire logic [31:0] mct_data,
   input wire logic rom_load_en,
   input wire logic rom_load_opcode,
   input wire logic [10:0] rom_load_addr,
   input wire logic [7:0] rom_load_data,
   output logic [7:0] dispatch_addr_r,
   output logic dispatch_valid_r,
   output logic byte_taken_r,
   output logic instr_byte_request_r,
   output logic dispatch_rom_select_r,
   output logic load_specifier_reg_r,
   output logic load_dest_mode_test_r,
   output logic compat_high_byte_select_r,
   output logic [1:0] specifier_reg_control_r,
   output logic decode_error_r,
   output logic register_mode_flag_r,
   output logic [7:0] operand_specifier_reg_r,
   output logic [3:0] alu_flags_r,
   output logic [3:0] program_status_flags_r,
   output logic [1:0] size_r,
   output logic [31:0] pc_r,
   output logic [31:0] dbus_r
);

   //////////////////////////////////////////////////////////////////////////
   // decode controls

   logic is_dec;
   logic instr_byte_request;
   logic rom_sel;
   logic load_specifier_reg;
   logic ld_rd;
   logic hi_sel;
   logic take_byte;
   logic do_disp;
   logic func_ok;
   logic [1:0] byte_sel;
   logic [7:0] ib_byte;
   logic [7:0] rom_byte;
   logic [7:0] spec_out;
   logic [7:0] opc_out;
   logic regmode;
   logic [7:0] opcode_r;
   idd_seq_e seq_r;
   idd_seq_e seq_nxt;
   idd_osctl_e osctl;

   assign is_dec = uop_valid && (uop.kind != KIND_NONE);

   always_comb begin
      instr_byte_request = 1'b0;
      rom_sel = 1'b0;
      load_specifier_reg = 1'b0;
      ld_rd = 1'b0;
      hi_sel = 1'b0;
      do_disp = 1'b0;
      func_ok = 1'b1;
      if (is_dec) begin
         case (uop.kind)
            KIND_CLASS: begin
               instr_byte_request = !compat_mode;
               hi_sel = compat_mode;
               load_specifier_reg = compat_mode;
               // a pending native interrupt steers the class dispatch to the specifier dispatch table
               rom_sel = compat_mode || !uop.irq_pending;
               do_disp = 1'b1;
               func_ok = compat_mode ? (uop.func == `IDD_FUNC_CM_CLASS)
                                     : (uop.func == `IDD_FUNC_NAT_CLASS);
            end
            KIND_SPEC: begin
               instr_byte_request = !compat_mode;
               rom_sel = 1'b0;
               load_specifier_reg = 1'b1;
               ld_rd = !compat_mode || (uop.func == `IDD_FUNC_CM_DEST);
               do_disp = 1'b1;
               if (compat_mode) begin
                  func_ok = uop.func[2:1] == 2'h3;
               end else begin
                  func_ok = (uop.func != 3'h3) && (uop.func[2:1] != 2'h3);
               end
            end
            KIND_OPCODE: begin
               rom_sel = 1'b1;
               do_disp = 1'b1;
               func_ok = !compat_mode && (uop.func == `IDD_FUNC_OPCODE);
            end
            KIND_GETBYTE: begin
               instr_byte_request = 1'b1;
               load_specifier_reg = 1'b1;
               func_ok = !compat_mode;
            end
            KIND_NOOPER: begin
               rom_sel = 1'b1;
               load_specifier_reg = 1'b1;
               do_disp = 1'b1;
               func_ok = compat_mode && (uop.func == `IDD_FUNC_CM_NOOPER);
            end
            default: begin
               func_ok = 1'b0;
            end
         endcase
      end
   end

   // a compat decode other than the opcode or get-byte decode removes a byte even though no byte request is made;
   // an opcode decode in either mode, and a native decode with no byte request, leave the buffer alone
   assign take_byte = is_dec && (instr_byte_request || (compat_mode && uop.kind != KIND_OPCODE));

   // compat code is word aligned, so pc bit 0 is replaced by the high-byte select;
   // following the special load the select is held low to keep the low byte
   always_comb begin
      if (compat_mode) begin
         byte_sel = {pc_r[1], hi_sel && (seq_r != SEQ_CMIRD || is_dec)};
      end else begin
         byte_sel = pc_r[1:0];
      end
   end

   assign ib_byte = prefetch_buffer[byte_sel*8 +: 8];
   assign rom_byte = (uop.kind == KIND_OPCODE) ? opcode_r : ib_byte;

   //////////////////////////////////////////////////////////////////////////
   // dispatch tables: block index is the decode function field

   idd_dispatch_rom #(.AW(11), .DW(8)) u_specifier_dispatch_rom (
      .clk_sys(clk_sys),
      .ld_en(rom_load_en && !rom_load_opcode),
      .ld_addr(rom_load_addr),
      .ld_data(rom_load_data),
      .rd_addr({uop.func, rom_byte}),
      .rd_data(spec_out)
   );

   idd_dispatch_rom #(.AW(11), .DW(8)) u_opc_rom (
      .clk_sys(clk_sys),
      .ld_en(rom_load_en && rom_load_opcode),
      .ld_addr(rom_load_addr),
      .ld_data(rom_load_data),
      .rd_addr({uop.func, rom_byte}),
      .rd_data(opc_out)
   );

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dispatch_addr_r <= 8'h00;
         dispatch_valid_r <= 1'b0;
      end else begin
         dispatch_valid_r <= do_disp;
         if (do_disp) begin
            dispatch_addr_r <= rom_sel ? opc_out : spec_out;
         end
      end
   end

   // control echoes, so the sequencer sees what the decode really asserted
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         byte_taken_r <= 1'b0;
         instr_byte_request_r <= 1'b0;
         dispatch_rom_select_r <= 1'b0;
         load_specifier_reg_r <= 1'b0;
         load_dest_mode_test_r <= 1'b0;
         compat_high_byte_select_r <= 1'b0;
         specifier_reg_control_r <= OSC_HOLD;
         decode_error_r <= 1'b0;
      end else begin
         byte_taken_r <= take_byte;
         instr_byte_request_r <= instr_byte_request;
         dispatch_rom_select_r <= rom_sel;
         load_specifier_reg_r <= load_specifier_reg;
         load_dest_mode_test_r <= ld_rd;
         compat_high_byte_select_r <= byte_sel[0] && compat_mode;
         specifier_reg_control_r <= osctl;
         decode_error_r <= is_dec && !func_ok;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // program counter and stored opcode

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pc_r <= `IDD_RST_PC;
      end else if (is_dec && instr_byte_request) begin
         pc_r <= pc_r + 32'h0000_0001;
      end else if (uop_valid && dp.pc_wr) begin
         pc_r <= ybus;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         opcode_r <= 8'h00;
      end else if (is_dec && uop.kind == KIND_CLASS) begin
         opcode_r <= ib_byte;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // compat follow-up sequencing and specifier register

   always_comb begin
      seq_nxt = seq_r;
      if (is_dec) begin
         seq_nxt = (compat_mode && uop.kind == KIND_CLASS) ? SEQ_CMIRD : SEQ_IDLE;
      end else if (uop_valid) begin
         seq_nxt = SEQ_IDLE;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         seq_r <= SEQ_IDLE;
      end else begin
         seq_r <= seq_nxt;
      end
   end

   always_comb begin
      osctl = OSC_HOLD;
      if (is_dec && load_specifier_reg) begin
         osctl = (ld_rd && compat_mode) ? OSC_LOADCLR3 : OSC_LOAD;
      end else if (uop_valid && !is_dec && seq_r == SEQ_CMIRD) begin
         osctl = OSC_SHIFT;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         operand_specifier_reg_r <= `IDD_RST_OS;
      end else begin
         case (osctl)
            OSC_LOAD: begin
               operand_specifier_reg_r <= ib_byte;
            end
            OSC_LOADCLR3: begin
               operand_specifier_reg_r <= ib_byte & `IDD_OS_CLR3;
            end
            OSC_SHIFT: begin
               operand_specifier_reg_r <= {operand_specifier_reg_r[5:2], 1'b0,
                  operand_specifier_reg_r[0], ib_byte[7:6]};
            end
            default: begin
               if (uop_valid && dp.rw_sel == RW_WR_OS) begin
                  operand_specifier_reg_r <= ybus[7:0];
               end
            end
         endcase
      end
   end

   // compat destination field keeps its mode in bits 5:3
   assign regmode = compat_mode ? (ib_byte[5:3] == `IDD_CM_REGMODE)
                                : (ib_byte[7:4] == `IDD_NAT_REGMODE);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         register_mode_flag_r <= 1'b0;
      end else if (is_dec && ld_rd) begin
         register_mode_flag_r <= regmode;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // condition codes and size register

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         alu_flags_r <= `IDD_RST_CC;
      end else if (uop_valid && dp.rw_sel == RW_WR_ALUCC) begin
         alu_flags_r <= ybus[3:0];
      end else if (uop_valid && dp.alu_cc_ld) begin
         alu_flags_r <= dp.alu_flags;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         program_status_flags_r <= `IDD_RST_CC;
      end else if (uop_valid && dp.cc_commit) begin
         program_status_flags_r <= alu_flags_r;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         size_r <= `IDD_RST_SIZE;
      end else if (is_dec && uop.kind == KIND_CLASS) begin
         size_r <= uop.class_size;
      end else if (uop_valid && dp.rw_sel == RW_WR_SIZE) begin
         size_r <= ybus[1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // local store

   logic [7:0] ls_addr;
   logic [3:0] ls_mask;
   logic [31:0] ls_rdata;

   always_comb begin
      case (dp.ls_idx)
         LSX_IDX4: ls_addr = {dp.ls_addr[7:4], operand_specifier_reg_r[3:0]};
         LSX_IDX5: ls_addr = {dp.ls_addr[7:5], operand_specifier_reg_r[4:0]};
         default: ls_addr = dp.ls_addr;
      endcase
   end

   always_comb begin
      ls_mask = `IDD_MASK_LONG;
      if (dp.ls_sized) begin
         case (size_r)
            `IDD_SIZE_BYTE: ls_mask = `IDD_MASK_BYTE;
            `IDD_SIZE_WORD: ls_mask = `IDD_MASK_WORD;
            default: ls_mask = `IDD_MASK_LONG;
         endcase
      end
   end

   idd_local_store #(.DEPTH(256), .WIDTH(32), .AW(8)) u_ls (
      .clk_sys(clk_sys),
      .we(uop_valid && dp.ls_we),
      .addr(ls_addr),
      .wdata(ybus),
      .wmask(ls_mask),
      .rdata(ls_rdata)
   );

   //////////////////////////////////////////////////////////////////////////
   // d bus multiplexer with sign extension

   function automatic logic [31:0] sext(input logic [31:0] v, input logic [1:0] sz);
      logic [31:0] r;
      r = v;
      case (sz)
         `IDD_SIZE_BYTE: r = {{24{v[7]}}, v[7:0]};
         `IDD_SIZE_WORD: r = {{16{v[15]}}, v[15:0]};
         default: r = v;
      endcase
      return r;
   endfunction : sext

   // a single select field picks the source, so two drivers can never overlap;
   // an idle cycle leaves the bus at zero rather than holding stale data
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dbus_r <= 32'h0000_0000;
      end else if (!uop_valid) begin
         dbus_r <= 32'h0000_0000;
      end else begin
         case (dp.rw_sel)
            RW_RD_OS: dbus_r <= sext({24'h00_0000, operand_specifier_reg_r},
                                     `IDD_SIZE_BYTE);
            RW_RD_ALUCC: dbus_r <= {28'h000_0000, alu_flags_r};
            RW_RD_PSLCC: dbus_r <= {28'h000_0000, program_status_flags_r};
            RW_RD_SIZE: dbus_r <= {30'h0000_0000, size_r};
            RW_RD_LS: dbus_r <= ls_rdata;
            RW_RD_MCT: dbus_r <= sext(mct_data, size_r);
            default: dbus_r <= 32'h0000_0000;
         endcase
      end
   end

endmodule : idd_decode_dispatch

/* idd_decode_dispatch_test.sv */
// self-checking bench for the decode and dispatch block
`timescale 1ns/100ps
module idd_decode_dispatch_test
   import idd_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic uop_valid = 1'b0;
   idd_uop_s uop = '0;
   idd_dp_s dp = '0;
   logic compat_mode = 1'b0;
   logic [31:0] ybus = 32'h0, mct_data = 32'h0, fill_word = 32'h0, pfb_w, pc, dbus;
   logic rom_load_en = 1'b0, rom_load_opcode = 1'b0, fill = 1'b0;
   logic [10:0] rom_load_addr = 11'h0;
   logic [7:0] rom_load_data = 8'h0, disp_addr, os;
   logic disp_v, taken, ibreq, romsel, load_specifier_reg, ld_dst, hisel, err, regm;
   logic [1:0] osctl, size;
   logic [3:0] aluf, pslf;
   int mismatches = 0, compares = 0, cycles = 0;
   always #20 clk_sys = ~clk_sys;
   idd_pfb_model u_pfb (.clk_sys, .rst, .fill, .fill_word, .prefetch_buffer(pfb_w));
   idd_decode_dispatch u_dut (.clk_sys, .rst, .uop_valid, .uop, .dp, .compat_mode,
      .prefetch_buffer(pfb_w), .ybus, .mct_data, .rom_load_en, .rom_load_opcode,
      .rom_load_addr, .rom_load_data, .dispatch_addr_r(disp_addr), .dispatch_valid_r(disp_v),
      .byte_taken_r(taken), .instr_byte_request_r(ibreq), .dispatch_rom_select_r(romsel),
      .load_specifier_reg_r(load_specifier_reg), .load_dest_mode_test_r(ld_dst),
      .compat_high_byte_select_r(hisel), .specifier_reg_control_r(osctl),
      .decode_error_r(err), .register_mode_flag_r(regm), .operand_specifier_reg_r(os),
      .alu_flags_r(aluf), .program_status_flags_r(pslf), .size_r(size), .pc_r(pc),
      .dbus_r(dbus));
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   // one microinstruction, then a valid non-decode (fol=1) or an idle cycle
   task automatic op(idd_kind_e k, logic [2:0] f, idd_dp_s d, logic [31:0] y, logic fol);
      @(posedge clk_sys);
      uop_valid <= 1'b1;
      uop <= '{k, f, 2'h0, 1'b0};
      dp <= d;
      ybus <= y;
      mct_data <= y;
      @(posedge clk_sys);
      uop_valid <= fol;
      uop.kind <= KIND_NONE;
      dp <= '0;
      @(negedge clk_sys);
   endtask : op
   task automatic load(logic tbl, logic [10:0] a, logic [7:0] v, logic [31:0] w);
      @(posedge clk_sys);
      rom_load_en <= 1'b1;
      rom_load_opcode <= tbl;
      rom_load_addr <= a;
      rom_load_data <= v;
      fill <= 1'b1;
      fill_word <= w;
      @(posedge clk_sys);
      rom_load_en <= 1'b0;
      fill <= 1'b0;
   endtask : load
   initial begin
      idd_dp_s d;
      logic [7:0] b;
      logic [31:0] w;
      int epc;
      logic [2:0] fn [5];
      fn = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h3};
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      chk(32'({size, osctl, os}), 32'hb00, "reset values");
      w = 32'h88c0_a555;
      load(1'b1, 11'h288, 8'h42, w);
      load(1'b0, 11'h62b, 8'h66, w);
      load(1'b0, 11'h7c7, 8'h77, w);
      load(1'b1, 11'h02b, 8'h0c, w);
      load(1'b0, 11'h155, 8'h31, w);
      op(KIND_SPEC, 3'h1, '0, 32'h0, 1'b0);
      chk(32'(disp_addr), 32'h31, "spec dispatch");
      chk(32'({disp_v, taken, ibreq, romsel, load_specifier_reg, ld_dst, regm}), 32'h77, "spec ctl");
      chk(32'({os, osctl}), 32'h154, "spec load");
      chk(pc, 32'h1, "pc step");
      epc = 1;
      for (int i = 0; i < 5; i++) begin
         b = 8'(w >> (8 * (epc % 4)));
         op(KIND_SPEC, fn[i], '0, 32'h0, 1'b0);
         epc++;
         chk(32'(os), 32'(b), "spec byte");
         chk(32'(err), 32'(fn[i] == 3'h3), "func legality");
         chk(32'(regm), 32'(b[7:4] == 4'h5), "register mode");
         chk(pc, 32'(epc), "pc step");
      end
      b = 8'(w >> (8 * (epc % 4)));
      op(KIND_GETBYTE, 3'h0, '0, 32'h0, 1'b0);
      chk(32'({disp_v, ibreq, load_specifier_reg, os}), 32'(b) | 32'h300, "get-byte");
      op(KIND_CLASS, 3'h3, '0, 32'h0, 1'b0);
      chk(32'(size), 32'h0, "class size");
      op(KIND_OPCODE, 3'h2, '0, 32'h0, 1'b0);
      chk(32'({disp_v, taken, ibreq, romsel, disp_addr}), 32'h942, "opcode");
      chk(pc, 32'(epc + 2), "opcode pc");
      $display("native decode tests done");
      d = '0;
      d.rw_sel = RW_WR_SIZE;
      op(KIND_NONE, 3'h0, d, 32'h1, 1'b0);
      d.rw_sel = RW_RD_MCT;
      op(KIND_NONE, 3'h0, d, 32'h8123, 1'b0);
      chk(dbus, 32'hffff_8123, "mct word sign");
      d.rw_sel = RW_WR_OS;
      op(KIND_NONE, 3'h0, d, 32'h9a, 1'b0);
      d.rw_sel = RW_RD_OS;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      chk(dbus, 32'hffff_ff9a, "os read sign");
      @(negedge clk_sys);
      chk(dbus, 32'h0, "d bus blank");
      d = '0;
      d.alu_cc_ld = 1'b1;
      d.alu_flags = 4'ha;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      chk(32'({aluf, pslf}), 32'ha0, "alu flags load");
      d = '0;
      d.cc_commit = 1'b1;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      d = '0;
      d.rw_sel = RW_WR_ALUCC;
      op(KIND_NONE, 3'h0, d, 32'h5, 1'b0);
      chk(32'({aluf, pslf}), 32'h5a, "flag copy and y load");
      d.rw_sel = RW_RD_PSLCC;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      chk(dbus, 32'ha, "program flags read");
      d.rw_sel = RW_RD_ALUCC;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      chk(dbus, 32'h5, "alu flags read");
      d.rw_sel = RW_RD_SIZE;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      chk(dbus, 32'h1, "size read");
      d = '0;
      d.ls_we = 1'b1;
      d.ls_addr = 8'h10;
      op(KIND_NONE, 3'h0, d, 32'haabb_ccdd, 1'b0);
      d.ls_sized = 1'b1;
      op(KIND_NONE, 3'h0, d, 32'h1234_5678, 1'b0);
      d.ls_sized = 1'b0;
      d.ls_idx = LSX_IDX4;
      d.ls_addr = 8'h20;
      op(KIND_NONE, 3'h0, d, 32'h777, 1'b0);
      d = '0;
      d.rw_sel = RW_RD_LS;
      d.ls_addr = 8'h10;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      chk(dbus, 32'haabb_5678, "sized store");
      d.ls_addr = 8'h2a;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      chk(dbus, 32'h777, "indexed store");
      d = '0;
      d.ls_we = 1'b1;
      d.ls_idx = LSX_IDX5;
      d.ls_addr = 8'h20;
      op(KIND_NONE, 3'h0, d, 32'h555, 1'b0);
      d = '0;
      d.rw_sel = RW_RD_LS;
      d.ls_addr = 8'h3a;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      chk(dbus, 32'h555, "five-bit indexed store");
      $display("data path tests done");
      @(posedge clk_sys);
      compat_mode <= 1'b1;
      load(1'b0, 11'h62b, 8'h66, 32'h5ac7_912b);
      d = '0;
      d.pc_wr = 1'b1;
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      op(KIND_SPEC, 3'h6, '0, 32'h0, 1'b0);
      chk(32'({ibreq, hisel, ld_dst, taken, regm}), 32'h6, "compat spec ctl");
      chk(32'({disp_addr, os, osctl}), 32'h1988e, "compat dest");
      op(KIND_NONE, 3'h0, d, 32'h2, 1'b0);
      op(KIND_SPEC, 3'h7, '0, 32'h0, 1'b0);
      chk(32'({disp_addr, os, osctl, ld_dst}), 32'h3be38, "compat single");
      op(KIND_NONE, 3'h0, d, 32'h0, 1'b0);
      op(KIND_NOOPER, 3'h0, '0, 32'h0, 1'b0);
      chk(32'({disp_addr, os, romsel, load_specifier_reg, ld_dst}), 32'h615e, "no-operand");
      op(KIND_CLASS, 3'h1, '0, 32'h0, 1'b1);
      chk(32'({os, hisel}), 32'h123, "compat class");
      @(posedge clk_sys);
      uop_valid <= 1'b0;
      @(negedge clk_sys);
      chk(32'({os, osctl, hisel}), 32'h222, "compat shift");
      $display("compat decode tests done");
      report_and_stop();
   end
endmodule : idd_decode_dispatch_test
bind idd_decode_dispatch idd_dd_properties u_props (.clk_sys, .rst, .uop_valid, .uop, .dp,
   .compat_mode, .prefetch_buffer, .operand_specifier_reg_r, .byte_taken_r,
   .instr_byte_request_r, .dispatch_rom_select_r, .load_dest_mode_test_r,
   .compat_high_byte_select_r, .specifier_reg_control_r, .alu_flags_r,
   .program_status_flags_r, .pc_r, .dbus_r);

/* idd_defs.svh */
// constant values for the instruction decode and dispatch block
`ifndef IDD_DEFS_SVH
`define IDD_DEFS_SVH
`define IDD_FUNC_CM_NOOPER 3'h0
`define IDD_FUNC_CM_CLASS 3'h1
`define IDD_FUNC_OPCODE 3'h2
`define IDD_FUNC_NAT_CLASS 3'h3
`define IDD_FUNC_CM_DEST 3'h6
`define IDD_FUNC_CM_SINGLE 3'h7
`define IDD_NAT_REGMODE 4'h5
`define IDD_CM_REGMODE 3'h0
`define IDD_SIZE_BYTE 2'h0
`define IDD_SIZE_WORD 2'h1
`define IDD_SIZE_LONG 2'h2
`define IDD_MASK_BYTE 4'h1
`define IDD_MASK_WORD 4'h3
`define IDD_MASK_LONG 4'hf
`define IDD_RST_SIZE 2'h2
`define IDD_RST_OS 8'h00
`define IDD_RST_CC 4'h0
`define IDD_RST_PC 32'h0000_0000
`define IDD_OS_CLR3 8'hf7
`endif

/* idd_dispatch_rom.sv */
// loadable dispatch table, read combinationally by the decoder
`timescale 1ns/100ps
module idd_dispatch_rom #(
   parameter int AW = 11,
   parameter int DW = 8
) (
   input wire logic clk_sys,
   input wire logic ld_en,
   input wire logic [AW-1:0] ld_addr,
   input wire logic [DW-1:0] ld_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // contents come from the loader port; no reset, as a real rom has none
   always_ff @(posedge clk_sys) begin
      if (ld_en) begin
         mem[ld_addr] <= ld_data;
      end
   end

   assign rd_data = mem[rd_addr];
endmodule : idd_dispatch_rom

/* idd_local_store.sv */
// local store ram with byte-lane write mask
`timescale 1ns/100ps
module idd_local_store #(
   parameter int DEPTH = 256,
   parameter int WIDTH = 32,
   parameter int AW = 8
) (
   input wire logic clk_sys,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [WIDTH/8-1:0] wmask,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [0:DEPTH-1];

   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < WIDTH/8; i++) begin
         if (we && wmask[i]) begin
            mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
         end
      end
   end

   assign rdata = mem[addr];
endmodule : idd_local_store

/* idd_pfb_model.sv */
// prefetch buffer stand-in feeding instruction bytes to the decoder
`timescale 1ns/100ps
module idd_pfb_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic fill,
   input wire logic [31:0] fill_word,
   output logic [31:0] prefetch_buffer
);
   logic valid_r;
   // until filled the lines flip every cycle so stale data never looks valid
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         valid_r <= 1'b0;
         prefetch_buffer <= 32'h5a5a_5a5a;
      end else if (fill) begin
         valid_r <= 1'b1;
         prefetch_buffer <= fill_word;
      end else if (!valid_r) begin
         prefetch_buffer <= ~prefetch_buffer;
      end
   end
endmodule : idd_pfb_model

/* idd_pkg.sv */
// types shared by the instruction decode and dispatch block
package idd_pkg;
   typedef enum logic [2:0] {
      KIND_NONE = 3'h0, KIND_CLASS = 3'h1, KIND_SPEC = 3'h2, KIND_OPCODE = 3'h3,
      KIND_GETBYTE = 3'h4, KIND_NOOPER = 3'h5
   } idd_kind_e;
   typedef enum logic [1:0] {
      OSC_LOAD = 2'h0, OSC_SHIFT = 2'h1, OSC_LOADCLR3 = 2'h2, OSC_HOLD = 2'h3
   } idd_osctl_e;
   typedef enum logic [3:0] {
      RW_NONE = 4'h0, RW_RD_OS = 4'h1, RW_RD_ALUCC = 4'h2, RW_RD_PSLCC = 4'h3,
      RW_RD_SIZE = 4'h4, RW_RD_LS = 4'h5, RW_RD_MCT = 4'h6, RW_WR_OS = 4'h7,
      RW_WR_ALUCC = 4'h8, RW_WR_SIZE = 4'h9
   } idd_rwsel_e;
   typedef enum logic [1:0] {LSX_NONE = 2'h0, LSX_IDX4 = 2'h1, LSX_IDX5 = 2'h2} idd_lsidx_e;
   typedef enum logic [0:0] {SEQ_IDLE = 1'b0, SEQ_CMIRD = 1'b1} idd_seq_e;
   typedef struct packed {
      idd_kind_e kind;
      logic [2:0] func;
      logic [1:0] class_size;
      logic irq_pending;
   } idd_uop_s;
   typedef struct packed {
      idd_rwsel_e rw_sel;
      logic [7:0] ls_addr;
      idd_lsidx_e ls_idx;
      logic ls_we;
      logic ls_sized;
      logic alu_cc_ld;
      logic [3:0] alu_flags;
      logic cc_commit;
      logic pc_wr;
   } idd_dp_s;
endpackage : idd_pkg
